/* File: core/luc_params.svh */
// offsets, field positions, reset values and counts of the lin/uart control block
// assumes one apb slave, 8-bit registers in the low bits of aligned 32-bit words
`ifndef LUC_PARAMS_SVH
`define LUC_PARAMS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LUC_OFS_CTRL 8'h00
`define LUC_OFS_STAT 8'h04
`define LUC_OFS_IRQEN 8'h08
`define LUC_OFS_ERR 8'h0C
`define LUC_OFS_BTR 8'h10
`define LUC_OFS_BRRL 8'h14
`define LUC_OFS_BRRH 8'h18
`define LUC_OFS_DLR 8'h1C
`define LUC_OFS_IDR 8'h20
`define LUC_OFS_SEL 8'h24
`define LUC_OFS_DAT 8'h28
// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define LUC_CTRL_SWRES 7
`define LUC_CTRL_V13 6
`define LUC_CTRL_ENA 3
`define LUC_CTRL_CMD_HI 2
`define LUC_STAT_ERR 3
`define LUC_STAT_IDOK 2
`define LUC_STAT_TXOK 1
`define LUC_STAT_RXOK 0
`define LUC_SEL_AINC 3
`define LUC_ERR_OVR 5
`define LUC_ERR_TO 6
`define LUC_ERR_ABT 7
`define LUC_CMD_ABORT 3'h0
`define LUC_CMD_TXHDR 3'h1
`define LUC_CONF_NONE 2'h1
`define LUC_CONF_NOTO 2'h2
`define LUC_CONF_LISTEN 2'h3
`define LUC_RSV_ID_HI 4'hF
`define LUC_BTR_RESET 8'h20
`define LUC_FRAME_TIMEOUT_CYC 50000
`endif

/* File: core/luc_pkg.sv */
// types of the lin/uart control block
// assumes luc_params.svh is available on the include path
package luc_pkg;
	// controller sequencing states, one-hot
	typedef enum logic [2:0] {
		LUC_IDLE = 3'b001,
		LUC_HDR = 3'b010,
		LUC_RESP = 3'b100
	} luc_state_t;
endpackage : luc_pkg

/* File: core/luc_ctrl.sv */
// control registers, frame buffer and sequencing of a lin/uart controller
// assumes an apb master on ref_clk and a bit-level link engine giving one-cycle event pulses
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "luc_params.svh"
module luc_ctrl
	import luc_pkg::*;
#(
	parameter int AW = 8,
	parameter int FRAME_TIMEOUT_CYC = `LUC_FRAME_TIMEOUT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dbgBreak,
	input wire logic hdrDone,
	input wire logic [5:0] hdrId,
	input wire logic linRxValid,
	input wire logic [7:0] linRxByte,
	input wire logic linTxTaken,
	input wire logic respDone,
	input wire logic [4:0] error_flag_reg,
	input wire logic uartRxValid,
	input wire logic [7:0] uartRxByte,
	input wire logic uartTxDone,
	output logic [7:0] linTxByte,
	output logic [7:0] uartTxData,
	output logic uartTxStart,
	output logic startTxHdr,
	output logic startResp,
	output logic abortPulse,
	output logic engineReset,
	output logic busy,
	output logic enabled,
	output logic uartMode,
	output logic protoV13,
	output logic inclIdInChecksum,
	output logic checksumOn,
	output logic timeoutOn,
	output logic listenMode,
	output logic [1:0] parityMode,
	output logic uartRxEn,
	output logic uartTxEn,
	output logic [11:0] baudDiv,
	output logic [7:0] bitTiming,
	output logic [7:0] dataLength
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] idStatus(input logic [5:0] id);
		idStatus = (id[5:2] == `LUC_RSV_ID_HI) ? {1'b1, id[1:0]} : 3'h0;
	endfunction : idStatus

	function automatic logic [7:0] withParity(input logic [5:0] id);
		withParity = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction : withParity

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	luc_state_t state_reg;
	logic softRst_reg;
	logic [6:0] ctrl_reg;
	logic [2:0] idSt_reg;
	logic idOk_reg, txOk_reg, rxOk_reg;
	logic [3:0] irqEn_reg;
	logic [7:0] err_reg;
	logic [7:0] btr_reg, brrl_reg, dlr_reg, prdata_reg;
	logic [3:0] brrh_reg;
	logic [5:0] idr_reg;
	logic [2:0] idx_reg, respCnt_reg;
	logic aincDis_reg, respTx_reg, inclId_reg;
	logic [7:0] frameBuf [8];
	logic [7:0] uartRx_reg, uartTx_reg, linTx_reg;
	logic uartTxStart_reg, startTxHdr_reg, startResp_reg, abort_reg;
	logic [31:0] timer_reg;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic access, wr, rd, mapped, ctrlReset;
	logic wrCtrl, wrStat, wrSel, wrDat, rdDat, cmdWrite;
	logic [2:0] newCmd;
	logic [7:0] rdMux;
	assign access = psel & penable;
	assign wr = access & pwrite;
	assign rd = access & ~pwrite;
	assign pready = 1'b1;
	assign mapped = paddr[1:0] == 2'h0 && paddr <= AW'(`LUC_OFS_DAT);
	assign pslverr = access & ~mapped;
	assign prdata = {24'h0, prdata_reg};
	assign wrCtrl = wr && paddr == AW'(`LUC_OFS_CTRL);
	assign wrStat = wr && paddr == AW'(`LUC_OFS_STAT);
	assign wrSel = wr && paddr == AW'(`LUC_OFS_SEL);
	assign wrDat = wr && paddr == AW'(`LUC_OFS_DAT);
	assign rdDat = rd && paddr == AW'(`LUC_OFS_DAT);
	assign newCmd = pwdata[`LUC_CTRL_CMD_HI:0];
	assign cmdWrite = wrCtrl & ~pwdata[`LUC_CTRL_SWRES] & pwdata[`LUC_CTRL_ENA];
	assign ctrlReset = rst | softRst_reg;

	// mode decode from the control register
	assign enabled = ctrl_reg[`LUC_CTRL_ENA];
	assign uartMode = ctrl_reg[`LUC_CTRL_CMD_HI];
	assign protoV13 = ctrl_reg[`LUC_CTRL_V13];
	assign listenMode = ctrl_reg[5:4] == `LUC_CONF_LISTEN;
	assign checksumOn = ~uartMode && ctrl_reg[5:4] != `LUC_CONF_NONE;
	assign timeoutOn = ~uartMode && ctrl_reg[5:4] != `LUC_CONF_NONE && ctrl_reg[5:4] != `LUC_CONF_NOTO;
	assign parityMode = (uartMode && ctrl_reg[5:4] != `LUC_CONF_LISTEN) ? ctrl_reg[5:4] : 2'h0;
	assign uartRxEn = enabled & uartMode & ctrl_reg[1];
	assign uartTxEn = enabled & uartMode & ctrl_reg[0];
	assign busy = state_reg != LUC_IDLE;
	assign inclIdInChecksum = inclId_reg;
	assign baudDiv = {brrh_reg, brrl_reg};
	assign bitTiming = btr_reg;
	assign dataLength = uartMode ? 8'h0 : dlr_reg;
	assign linTxByte = linTx_reg;
	assign uartTxData = uartTx_reg;
	assign uartTxStart = uartTxStart_reg;
	assign startTxHdr = startTxHdr_reg;
	assign startResp = startResp_reg;
	assign abortPulse = abort_reg;
	assign engineReset = softRst_reg;

	// ----------------------------------------------------------------
	// link events, gated by debugger break
	// ----------------------------------------------------------------
	logic run, hdrAccept, respEnd, timeoutHit, linCmd;
	logic [7:0] errSet;
	assign run = ~dbgBreak & enabled;
	assign linCmd = cmdWrite & ~newCmd[`LUC_CTRL_CMD_HI];
	assign hdrAccept = run & hdrDone & ~uartMode & (state_reg == LUC_HDR || (state_reg == LUC_IDLE
		&& ctrl_reg[2:0] == `LUC_CMD_ABORT));
	assign respEnd = run & respDone & state_reg == LUC_RESP;
	assign timeoutHit = run & timeoutOn & busy & timer_reg == 32'(FRAME_TIMEOUT_CYC - 1);
	assign errSet[4:0] = (run & busy) ? error_flag_reg : 5'h0;
	assign errSet[`LUC_ERR_OVR] = (linCmd & busy & newCmd != `LUC_CMD_ABORT) | (run & uartMode & uartRxValid & rxOk_reg);
	assign errSet[`LUC_ERR_TO] = timeoutHit;
	assign errSet[`LUC_ERR_ABT] = linCmd & busy & newCmd == `LUC_CMD_ABORT;

	// read multiplexer, sampled in the setup cycle
	always_comb begin
		case (paddr)
			AW'(`LUC_OFS_CTRL): rdMux = {softRst_reg, ctrl_reg};
			AW'(`LUC_OFS_STAT): rdMux = {idSt_reg, busy, |err_reg, idOk_reg, txOk_reg, rxOk_reg};
			AW'(`LUC_OFS_IRQEN): rdMux = {4'h0, irqEn_reg};
			AW'(`LUC_OFS_ERR): rdMux = err_reg;
			AW'(`LUC_OFS_BTR): rdMux = btr_reg;
			AW'(`LUC_OFS_BRRL): rdMux = brrl_reg;
			AW'(`LUC_OFS_BRRH): rdMux = {4'h0, brrh_reg};
			AW'(`LUC_OFS_DLR): rdMux = dataLength;
			AW'(`LUC_OFS_IDR): rdMux = withParity(idr_reg);
			AW'(`LUC_OFS_SEL): rdMux = {4'h0, aincDis_reg, idx_reg};
			AW'(`LUC_OFS_DAT): rdMux = uartMode ? uartRx_reg : frameBuf[idx_reg];
			default: rdMux = 8'h0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prdata_reg <= 8'h0;
		end else if (psel & ~penable) begin
			prdata_reg <= rdMux;
		end
	end

	// ----------------------------------------------------------------
	// control register and soft reset
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			softRst_reg <= 1'b0;
		end else begin
			softRst_reg <= wrCtrl & pwdata[`LUC_CTRL_SWRES];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (ctrlReset) begin
			ctrl_reg <= 7'h0;
		end else if (wrCtrl & ~pwdata[`LUC_CTRL_SWRES]) begin
			ctrl_reg <= pwdata[6:0];
		end else if (~uartMode & (|errSet)) begin
			ctrl_reg[2:0] <= `LUC_CMD_ABORT;
		end
	end

	// ----------------------------------------------------------------
	// sequencing state machine and command pulses
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (ctrlReset) begin
			state_reg <= LUC_IDLE;
			respTx_reg <= 1'b0;
			inclId_reg <= 1'b0;
			startTxHdr_reg <= 1'b0;
			startResp_reg <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			startTxHdr_reg <= 1'b0;
			startResp_reg <= 1'b0;
			abort_reg <= 1'b0;
			if (linCmd) begin
				if (busy | newCmd == `LUC_CMD_ABORT) begin
					state_reg <= LUC_IDLE;
					abort_reg <= busy;
				end else if (newCmd == `LUC_CMD_TXHDR) begin
					state_reg <= LUC_HDR;
					startTxHdr_reg <= 1'b1;
				end else begin
					state_reg <= LUC_RESP;
					respTx_reg <= newCmd[0];
					inclId_reg <= ~pwdata[`LUC_CTRL_V13];
					startResp_reg <= 1'b1;
				end
			end else if (cmdWrite | (wrCtrl & ~pwdata[`LUC_CTRL_ENA])) begin
				state_reg <= LUC_IDLE;
			end else if (run) begin
				case (state_reg)
					LUC_IDLE: state_reg <= LUC_IDLE;
					LUC_HDR: state_reg <= (hdrAccept | (|errSet)) ? LUC_IDLE : LUC_HDR;
					LUC_RESP: state_reg <= (respEnd | (|errSet)) ? LUC_IDLE : LUC_RESP;
					default: state_reg <= LUC_IDLE;
				endcase
			end
		end
	end

	// frame time-out counter, frozen by debugger break
	always_ff @(posedge ref_clk) begin
		if (ctrlReset | ~busy | linCmd) begin
			timer_reg <= 32'h0;
		end else if (run & timeoutOn) begin
			timer_reg <= timer_reg + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// status flags, set wins over clear
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (ctrlReset) begin
			idSt_reg <= 3'h0;
			idr_reg <= 6'h0;
			idOk_reg <= 1'b0;
			txOk_reg <= 1'b0;
			rxOk_reg <= 1'b0;
		end else begin
			if (hdrAccept) begin
				idSt_reg <= idStatus(hdrId);
				idr_reg <= hdrId;
			end else if (wr && paddr == AW'(`LUC_OFS_IDR)) begin
				idr_reg <= pwdata[5:0];
			end
			idOk_reg <= hdrAccept | (idOk_reg & ~(wrStat & pwdata[`LUC_STAT_IDOK]));
			txOk_reg <= (respEnd & respTx_reg) | (run & uartMode & uartTxDone)
				| (txOk_reg & ~(wrStat & pwdata[`LUC_STAT_TXOK]) & ~(wrDat & uartMode));
			rxOk_reg <= (respEnd & ~respTx_reg) | (run & uartMode & uartRxValid)
				| (rxOk_reg & ~(wrStat & pwdata[`LUC_STAT_RXOK]) & ~(rdDat & uartMode));
		end
	end

	// error flags, cleared together through the summary bit
	always_ff @(posedge ref_clk) begin
		if (ctrlReset) begin
			err_reg <= 8'h0;
		end else if ((wrStat & pwdata[`LUC_STAT_ERR]) | (rdDat & uartMode)) begin
			err_reg <= errSet;
		end else begin
			err_reg <= err_reg | errSet;
		end
	end

	// ----------------------------------------------------------------
	// plain configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (ctrlReset) begin
			irqEn_reg <= 4'h0;
			btr_reg <= `LUC_BTR_RESET;
			brrl_reg <= 8'h0;
			brrh_reg <= 4'h0;
			dlr_reg <= 8'h0;
		end else if (wr) begin
			if (paddr == AW'(`LUC_OFS_IRQEN)) irqEn_reg <= pwdata[3:0];
			if (paddr == AW'(`LUC_OFS_BTR)) btr_reg <= {pwdata[7], 1'b0, pwdata[5:0]};
			if (paddr == AW'(`LUC_OFS_BRRL)) brrl_reg <= pwdata[7:0];
			if (paddr == AW'(`LUC_OFS_BRRH)) brrh_reg <= pwdata[3:0];
			if (paddr == AW'(`LUC_OFS_DLR) && !uartMode) dlr_reg <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// frame buffer, index and uart data
	// ----------------------------------------------------------------
	logic datLin, engRx;
	assign datLin = (wrDat | rdDat) & ~uartMode;
	assign engRx = run & linRxValid & state_reg == LUC_RESP & ~respTx_reg;

	always_ff @(posedge ref_clk) begin
		if (ctrlReset) begin
			idx_reg <= 3'h0;
			aincDis_reg <= 1'b0;
		end else if (wrSel & ~uartMode) begin
			idx_reg <= pwdata[2:0];
			aincDis_reg <= pwdata[`LUC_SEL_AINC];
		end else if (datLin & ~aincDis_reg) begin
			idx_reg <= idx_reg + 3'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (engRx) begin
			frameBuf[respCnt_reg] <= linRxByte;
		end else if (wrDat & ~uartMode) begin
			frameBuf[idx_reg] <= pwdata[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (ctrlReset | startResp_reg) begin
			respCnt_reg <= 3'h0;
			linTx_reg <= 8'h0;
		end else begin
			if (engRx | (run & linTxTaken & respTx_reg)) respCnt_reg <= respCnt_reg + 3'h1;
			linTx_reg <= frameBuf[respCnt_reg];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (ctrlReset) begin
			uartRx_reg <= 8'h0;
			uartTx_reg <= 8'h0;
			uartTxStart_reg <= 1'b0;
		end else begin
			if (run & uartRxEn & uartRxValid) uartRx_reg <= uartRxByte;
			if (wrDat & uartMode) uartTx_reg <= pwdata[7:0];
			uartTxStart_reg <= wrDat & uartTxEn;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_id_status_map: assert property (@(posedge ref_clk) disable iff (ctrlReset)
		hdrAccept |=> idSt_reg == idStatus($past(hdrId))) else $error("identifier status wrong");
	a_index_advance: assert property (@(posedge ref_clk) disable iff (ctrlReset)
		datLin & ~aincDis_reg & ~wrSel |=> idx_reg == $past(idx_reg) + 3'h1) else $error("index did not advance");
	a_index_hold: assert property (@(posedge ref_clk) disable iff (ctrlReset)
		datLin & aincDis_reg & ~wrSel |=> $stable(idx_reg)) else $error("index moved while disabled");
	a_soft_reset_clears: assert property (@(posedge ref_clk) disable iff (rst)
		wrCtrl & pwdata[7] |=> softRst_reg ##1 !softRst_reg && ctrl_reg == 7'h0) else $error("soft reset stuck");
	a_checksum_latch: assert property (@(posedge ref_clk) disable iff (ctrlReset)
		startResp_reg |-> inclId_reg == !$past(pwdata[6])) else $error("checksum choice not latched");
	a_error_clear: assert property (@(posedge ref_clk) disable iff (ctrlReset)
		wrStat & pwdata[3] & ~(|errSet) |=> err_reg == 8'h0) else $error("error flags not cleared");
	a_idok_cause: assert property (@(posedge ref_clk) disable iff (ctrlReset)
		$rose(idOk_reg) |-> $past(hdrAccept) && !$past(uartMode)) else $error("identifier ok without header");
	a_cmd_needs_enable: assert property (@(posedge ref_clk) disable iff (ctrlReset)
		wrCtrl & ~pwdata[3] |=> !startTxHdr_reg && !startResp_reg && state_reg == LUC_IDLE) else $error("command while off");
	a_debug_freeze: assert property (@(posedge ref_clk) disable iff (ctrlReset)
		dbgBreak & ~wrCtrl |=> $stable(state_reg) && $stable(timer_reg)) else $error("state moved in break");
endmodule : luc_ctrl

/* File: tb/luc_line_model.sv */
// far-side model of the lin/uart line engine driving event pulses into luc_ctrl
// assumes rising-edge timing on ref_clk; released data lines show the inverse of their last value
`timescale 1ns/1ps
module luc_line_model (
	input wire logic ref_clk,
	input wire logic uartTxStart,
	output logic hdrDone,
	output logic [5:0] hdrId,
	output logic linRxValid,
	output logic [7:0] linRxByte,
	output logic uartRxValid,
	output logic [7:0] uartRxByte,
	output logic uartTxDone
);
	int txWait = 0;
	int txCount = 0;
	// idle levels at time zero
	initial begin
		hdrDone = 1'b0;
		hdrId = 6'h00;
		linRxValid = 1'b0;
		linRxByte = 8'h00;
		uartRxValid = 1'b0;
		uartRxByte = 8'h00;
		uartTxDone = 1'b0;
	end
	// header end with identifier
	task automatic send_hdr(input logic [5:0] id);
		@(posedge ref_clk);
		hdrDone <= 1'b1;
		hdrId <= id;
		@(posedge ref_clk);
		hdrDone <= 1'b0;
		hdrId <= ~id;
	endtask : send_hdr
	// response bytes arrive in frame order after an optional gap
	task automatic send_byte(input logic [7:0] b, input int gap);
		repeat (gap) @(posedge ref_clk);
		@(posedge ref_clk);
		linRxValid <= 1'b1;
		linRxByte <= b;
		@(posedge ref_clk);
		linRxValid <= 1'b0;
		linRxByte <= ~b;
	endtask : send_byte
	// one received uart character
	task automatic send_uart(input logic [7:0] b);
		@(posedge ref_clk);
		uartRxValid <= 1'b1;
		uartRxByte <= b;
		@(posedge ref_clk);
		uartRxValid <= 1'b0;
		uartRxByte <= ~b;
	endtask : send_uart
	// transmit completion, alternately slow and prompt
	always @(posedge ref_clk) begin
		uartTxDone <= 1'b0;
		if (txWait > 0) begin
			txWait <= txWait - 1;
			if (txWait == 1)
				uartTxDone <= 1'b1;
		end else if (uartTxStart === 1'b1) begin
			txWait <= (txCount % 2 == 0) ? 9 : 1;
			txCount <= txCount + 1;
		end
	end
endmodule : luc_line_model

/* File: tb/lin_uart_control_and_buffer_test.sv */
// self-checking bench for luc_ctrl: apb master, reference buffer model, line model
// assumes luc_line_model and luc_params.svh; timeout shortened to 20 cycles
`timescale 1ns/1ps
`include "luc_params.svh"
module lin_uart_control_and_buffer_test;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, err, dbgBreak;
	logic [7:0] paddr, linRxByte, uartRxByte, linTxByte, uartTxData, bitTiming, dataLength;
	logic [31:0] pwdata, prdata, q;
	logic hdrDone, linRxValid, respDone, uartRxValid, uartTxDone, uartTxStart, startTxHdr;
	logic startResp, abortPulse, engineReset, busy, enabled, uartMode, protoV13, inclIdInChecksum;
	logic checksumOn, timeoutOn, listenMode, uartRxEn, uartTxEn;
	logic [5:0] hdrId;
	logic [1:0] parityMode;
	logic [11:0] baudDiv;
	logic linTxTaken = 1'b0;
	logic [4:0] error_flag_reg = 5'h00;
	int fails = 0;
	int check_count = 0;
	int mem[8];
	int idx, n;
	luc_ctrl #(.FRAME_TIMEOUT_CYC(20)) dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .dbgBreak, .hdrDone, .hdrId, .linRxValid, .linRxByte,
		.linTxTaken, .respDone, .error_flag_reg, .uartRxValid, .uartRxByte, .uartTxDone, .linTxByte,
		.uartTxData, .uartTxStart, .startTxHdr, .startResp, .abortPulse, .engineReset, .busy,
		.enabled, .uartMode, .protoV13, .inclIdInChecksum, .checksumOn, .timeoutOn, .listenMode,
		.parityMode, .uartRxEn, .uartTxEn, .baudDiv, .bitTiming, .dataLength);
	luc_line_model lm (.ref_clk, .uartTxStart, .hdrDone, .hdrId, .linRxValid, .linRxByte,
		.uartRxValid, .uartRxByte, .uartTxDone);
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk);
	endtask : tick
	// one apb transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// the wait ends at the first edge that sees pready high; the watchdog bounds it
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// ----------------------------------------------------------------
	// clock, watchdog, main sequence
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		report_and_stop;
	end
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		dbgBreak = 1'b0;
		respDone = 1'b0;
		void'($urandom(30648));
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		apb(0, `LUC_OFS_CTRL, 0);
		chk(q, 32'h0);
		apb(0, `LUC_OFS_BTR, 0);
		chk(q, 32'h20);
		apb(0, `LUC_OFS_IDR, 0);
		chk(q, 32'h80);
		// configuration and mode decode, lin then every uart command
		for (int c = 0; c < 4; c++) begin
			apb(1, `LUC_OFS_CTRL, 8 | (c << 4));
			tick(1);
			chk(checksumOn, c != 1);
			chk(timeoutOn, c == 0 || c == 3);
			chk({enabled, uartMode, listenMode}, {2'b10, c == 3});
			for (int m = 4; m < 8; m++) begin
				apb(1, `LUC_OFS_CTRL, 8 | (c << 4) | m);
				tick(1);
				chk({uartMode, uartRxEn, uartTxEn}, {1'b1, m[1], m[0]});
				chk(listenMode, c == 3);
				chk(parityMode, (c == 3) ? 0 : c);
			end
		end
		// command ignored while disabled, then tx header
		apb(1, `LUC_OFS_CTRL, 32'h01);
		tick(1);
		chk({enabled, startTxHdr}, 2'b00);
		apb(1, `LUC_OFS_CTRL, 32'h09);
		tick(1);
		chk({startTxHdr, busy}, 2'b11);
		tick(1);
		chk(startTxHdr, 0);
		lm.send_hdr(6'h3D);
		apb(0, `LUC_OFS_STAT, 0);
		chk(q[7:2], 6'b101001);
		apb(1, `LUC_OFS_STAT, 32'h04);
		// reserved identifiers and an ordinary one
		apb(1, `LUC_OFS_CTRL, 32'h08);
		for (int i = 0; i < 5; i++) begin
			n = (i < 4) ? 60 + i : $urandom_range(59, 0);
			lm.send_hdr(n[5:0]);
			apb(0, `LUC_OFS_STAT, 0);
			chk({q[7], q[2]}, {n >= 60, 1'b1});
			if (n >= 60)
				chk(q[6:5], n[1:0]);
			apb(1, `LUC_OFS_STAT, 32'h04);
		end
		// debugger break drops events and freezes the frame timer
		dbgBreak <= 1'b1;
		lm.send_hdr(6'h3E);
		apb(0, `LUC_OFS_STAT, 0);
		chk(q[2], 0);
		apb(1, `LUC_OFS_CTRL, 32'h0A);
		tick(40);
		apb(0, `LUC_OFS_ERR, 0);
		chk(q[6], 0);
		dbgBreak <= 1'b0;
		tick(25);
		apb(0, `LUC_OFS_ERR, 0);
		chk(q[6], 1);
		apb(1, `LUC_OFS_STAT, 32'h08);
		// abort then overrun while busy, each cleared through the summary flag
		for (int i = 0; i < 2; i++) begin
			apb(1, `LUC_OFS_CTRL, 32'h0A);
			apb(1, `LUC_OFS_CTRL, i ? 32'h0B : 32'h08);
			tick(1);
			chk(abortPulse, 1);
			apb(0, `LUC_OFS_ERR, 0);
			chk(q, i ? 32'h20 : 32'h80);
			apb(0, `LUC_OFS_STAT, 0);
			chk(q[4:3], 2'b01);
			apb(1, `LUC_OFS_STAT, 32'h08);
			apb(0, `LUC_OFS_ERR, 0);
			chk(q, 32'h0);
		end
		// protocol bit and identifier-in-checksum latch
		apb(1, `LUC_OFS_CTRL, 32'h4A);
		tick(2);
		chk({protoV13, inclIdInChecksum}, 2'b10);
		apb(1, `LUC_OFS_CTRL, 32'h00);
		apb(1, `LUC_OFS_CTRL, 32'h0A);
		tick(2);
		chk({protoV13, inclIdInChecksum}, 2'b01);
		apb(1, `LUC_OFS_CTRL, 32'h00);
		apb(1, `LUC_OFS_STAT, 32'h08);
		// frame buffer with auto-increment, wrapping past 7
		apb(1, `LUC_OFS_SEL, 32'h00);
		idx = 0;
		for (int i = 0; i < 10; i++) begin
			n = $urandom_range(255, 0);
			mem[idx] = n;
			idx = (idx + 1) % 8;
			apb(1, `LUC_OFS_DAT, n);
		end
		apb(0, `LUC_OFS_SEL, 0);
		chk(q, idx);
		apb(1, `LUC_OFS_SEL, 32'h00);
		for (int i = 0; i < 8; i++) begin
			apb(0, `LUC_OFS_DAT, 0);
			chk(q, mem[i]);
		end
		// increment disabled: index rewritten before each access
		for (int i = 7; i >= 0; i--) begin
			apb(1, `LUC_OFS_SEL, 8 | i);
			apb(0, `LUC_OFS_DAT, 0);
			chk(q, mem[i]);
			apb(0, `LUC_OFS_SEL, 0);
			chk(q, 8 | i);
		end
		// receive response stored from index 0, no time-out configured
		apb(1, `LUC_OFS_CTRL, 32'h2A);
		tick(1);
		chk(startResp, 1);
		n = $urandom_range(8, 1);
		for (int i = 0; i < n; i++) begin
			mem[i] = $urandom_range(255, 0);
			lm.send_byte(mem[i][7:0], (i % 2) * 5);
		end
		@(posedge ref_clk);
		respDone <= 1'b1;
		@(posedge ref_clk);
		respDone <= 1'b0;
		apb(0, `LUC_OFS_STAT, 0);
		chk({q[4], q[0]}, 2'b01);
		apb(1, `LUC_OFS_SEL, 32'h00);
		for (int i = 0; i < 8; i++) begin
			apb(0, `LUC_OFS_DAT, 0);
			chk(q, mem[i]);
		end
		// transmit response hands buffer bytes out in frame order
		apb(1, `LUC_OFS_CTRL, 32'h2B);
		tick(3);
		chk(linTxByte, mem[0]);
		linTxTaken <= 1'b1;
		tick(1);
		linTxTaken <= 1'b0;
		tick(2);
		chk(linTxByte, mem[1]);
		respDone <= 1'b1;
		tick(1);
		respDone <= 1'b0;
		apb(0, `LUC_OFS_STAT, 0);
		chk(q[1:0], 2'b11);
		// engine error during a header ends it and shows in the error flags
		apb(1, `LUC_OFS_CTRL, 32'h29);
		n = $urandom_range(31, 1);
		error_flag_reg <= n[4:0];
		tick(1);
		error_flag_reg <= 5'h00;
		apb(0, `LUC_OFS_ERR, 0);
		chk(q, n);
		apb(0, `LUC_OFS_STAT, 0);
		chk(q[4:3], 2'b01);
		apb(1, `LUC_OFS_STAT, 32'h08);
		// uart: unbuffered data register, select ignored, no identifier flag
		apb(1, `LUC_OFS_CTRL, 32'h0F);
		apb(1, `LUC_OFS_SEL, 32'h05);
		apb(0, `LUC_OFS_SEL, 0);
		chk(q, 32'h0);
		n = $urandom_range(255, 0);
		lm.send_uart(n[7:0]);
		apb(0, `LUC_OFS_DAT, 0);
		chk(q, n);
		apb(0, `LUC_OFS_STAT, 0);
		chk(q[0], 0);
		n = $urandom_range(255, 0);
		apb(1, `LUC_OFS_DAT, n);
		tick(1);
		chk({uartTxStart, uartTxData}, {1'b1, n[7:0]});
		lm.send_hdr(6'h3C);
		tick(12);
		apb(0, `LUC_OFS_STAT, 0);
		chk(q[2:1], 2'b01);
		chk(dataLength, 0);
		// soft reset clears itself; unmapped word refused
		apb(1, `LUC_OFS_CTRL, 32'hAF);
		tick(1);
		chk(engineReset, 1);
		tick(3);
		apb(0, `LUC_OFS_CTRL, 0);
		chk(q, 32'h0);
		apb(0, 8'h2C, 0);
		chk({err, q}, {1'b1, 32'h0});
		report_and_stop;
	end
endmodule : lin_uart_control_and_buffer_test
